// [hold_defs.svh]
// Register offsets, field positions, widths and reset values of the holding and interrupt block
`ifndef HOLD_DEFS_SVH
`define HOLD_DEFS_SVH

`define ADDR_W 8
`define DATA_W 32
`define BYTE_W 8
`define IRQ_W 9

`define REG_STATUS 8'h20
`define REG_IRQ_ENABLE 8'h24
`define REG_IRQ_DISABLE 8'h28
`define REG_IRQ_MASK 8'h2c
`define REG_RX_HOLD 8'h30
`define REG_TX_HOLD 8'h34

`define BIT_TRANSFER_COMPLETED 0
`define BIT_RECEIVE_HOLDING_FULL 1
`define BIT_TRANSMIT_HOLDING_EMPTY 2
`define BIT_RECEIVE_OVERRUN_ERROR 6
`define BIT_TRANSMIT_UNDERRUN_ERROR 7
`define BIT_NACK 8

`define IRQ_DEFINED_BITS 9'h1c7
`define IRQ_ENABLE_RST 9'h000
`define STATUS_RST 9'h004
`define BYTE_RST 8'h00
`define WORD_ZERO 32'h0000_0000

`endif

// [hold_pkg.sv]
// Types shared by the holding and interrupt block
package hold_pkg;
`include "hold_defs.svh"

  typedef logic [`ADDR_W-1:0] addr_t;
  typedef logic [`DATA_W-1:0] word_t;
  typedef logic [`BYTE_W-1:0] byte_t;
  typedef logic [`IRQ_W-1:0] irq_bits_t;

  typedef struct packed {
    word_t rdata;
    irq_bits_t enable;
    irq_bits_t status;
    logic irq;
  } regs_state_t;

  typedef struct packed {
    byte_t rx_byte;
    logic rx_full;
    byte_t tx_byte;
    logic tx_full;
    logic rx_arrived;
    logic overrun;
    logic tx_emptied;
    logic underrun;
  } hold_state_t;

endpackage

// [hold_if.sv]
// Link between the register file and the byte holding stage
`timescale 1ns/10ps
interface hold_if;
  import hold_pkg::*;
  byte_t rx_byte;
  byte_t tx_byte;
  logic rx_full;
  logic tx_full;
  logic rx_arrived;
  logic overrun;
  logic tx_emptied;
  logic underrun;
  logic rx_read;
  logic tx_write;
  byte_t tx_wdata;

  modport regs (input rx_byte, tx_byte, rx_full, tx_full, rx_arrived, overrun, tx_emptied,
    underrun, output rx_read, tx_write, tx_wdata);
  modport hold (output rx_byte, tx_byte, rx_full, tx_full, rx_arrived, overrun, tx_emptied,
    underrun, input rx_read, tx_write, tx_wdata);
endinterface

// [byte_holding.sv]
// Receive and transmit holding bytes with their full and empty tracking
`timescale 1ns/10ps
module byte_holding (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic rx_valid_i,
  input wire hold_pkg::byte_t rx_byte_i,
  input wire logic tx_take_i,
  hold_if.hold hif
);
  import hold_pkg::*;

  hold_state_t st_ff;
  hold_state_t nxt_st;

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.rx_arrived = 1'b0;
    nxt_st.overrun = 1'b0;
    nxt_st.tx_emptied = 1'b0;
    nxt_st.underrun = 1'b0;
    // Software read frees the byte; an arrival in the same cycle keeps it full
    if (hif.rx_read)
      nxt_st.rx_full = 1'b0;
    if (rx_valid_i)
    begin
      nxt_st.rx_byte = rx_byte_i;
      nxt_st.rx_full = 1'b1;
      nxt_st.rx_arrived = 1'b1;
      // An unread byte is overwritten, so the newest byte always wins
      nxt_st.overrun = st_ff.rx_full && !hif.rx_read;
    end
    if (tx_take_i)
    begin
      nxt_st.tx_full = 1'b0;
      nxt_st.tx_emptied = st_ff.tx_full;
      nxt_st.underrun = !st_ff.tx_full;
    end
    if (hif.tx_write)
    begin
      nxt_st.tx_byte = hif.tx_wdata;
      nxt_st.tx_full = 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      st_ff <= '{rx_byte: `BYTE_RST, tx_byte: `BYTE_RST, default: 1'b0};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign hif.rx_byte = st_ff.rx_byte;
  assign hif.tx_byte = st_ff.tx_byte;
  assign hif.rx_full = st_ff.rx_full;
  assign hif.tx_full = st_ff.tx_full;
  assign hif.rx_arrived = st_ff.rx_arrived;
  assign hif.overrun = st_ff.overrun;
  assign hif.tx_emptied = st_ff.tx_emptied;
  assign hif.underrun = st_ff.underrun;

endmodule // byte_holding

// [serial_irq_regs.sv]
// Interrupt enable, disable, mask, status and holding registers of a two-wire bus controller
`timescale 1ns/10ps
module serial_irq_regs (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire hold_pkg::addr_t addr_i,
  input wire hold_pkg::word_t wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output hold_pkg::word_t rdata_o,
  output logic irq_o,
  input wire logic transfer_done_i,
  input wire logic nack_i,
  input wire logic rx_valid_i,
  input wire hold_pkg::byte_t rx_byte_i,
  input wire logic tx_take_i,
  output hold_pkg::byte_t tx_byte_o,
  output logic tx_valid_o
);
  import hold_pkg::*;

  regs_state_t st_ff;
  regs_state_t nxt_st;
  hold_if hif ();

  // Keeps only the defined source bits, so reserved bits can never be set
  function automatic irq_bits_t field_bits(input word_t w);
    field_bits = w[`IRQ_W-1:0] & `IRQ_DEFINED_BITS;
  endfunction

  // Places a source vector into a bus word with reserved bits at zero
  function automatic word_t to_word(input irq_bits_t b);
    to_word = {{(`DATA_W-`IRQ_W){1'b0}}, b & `IRQ_DEFINED_BITS};
  endfunction

  // Places a byte into the low lane of a bus word
  function automatic word_t byte_word(input byte_t b);
    byte_word = {{(`DATA_W-`BYTE_W){1'b0}}, b};
  endfunction

  function automatic logic hit(input addr_t a, input addr_t offs);
    hit = (a == offs);
  endfunction

  byte_holding u_hold (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .rx_valid_i(rx_valid_i),
    .rx_byte_i(rx_byte_i),
    .tx_take_i(tx_take_i),
    .hif(hif.hold)
  );

  irq_bits_t events;
  irq_bits_t status_clear;
  logic rd_status;
  logic rd_enable_reg;

  // Strobes toward the holding stage are decoded in the same cycle as the access
  always_comb
  begin
    hif.rx_read = rd_i && hit(addr_i, `REG_RX_HOLD);
    hif.tx_write = wr_i && hit(addr_i, `REG_TX_HOLD);
    hif.tx_wdata = wdata_i[`BYTE_W-1:0];
  end

  // Events from the holding stage and from the protocol engine
  always_comb
  begin
    events = '0;
    events[`BIT_TRANSFER_COMPLETED] = transfer_done_i;
    events[`BIT_RECEIVE_HOLDING_FULL] = hif.rx_arrived;
    events[`BIT_TRANSMIT_HOLDING_EMPTY] = hif.tx_emptied;
    events[`BIT_RECEIVE_OVERRUN_ERROR] = hif.overrun;
    events[`BIT_TRANSMIT_UNDERRUN_ERROR] = hif.underrun;
    events[`BIT_NACK] = nack_i;
  end

  always_comb
  begin
    rd_status = rd_i && hit(addr_i, `REG_STATUS);
    rd_enable_reg = rd_i && hit(addr_i, `REG_IRQ_MASK);
    status_clear = rd_status ? `IRQ_DEFINED_BITS : '0;
  end

  always_comb
  begin
    nxt_st = st_ff;

    // Enable and disable act as set and clear ports of one mask, so no read-modify-write
    if (wr_i && hit(addr_i, `REG_IRQ_ENABLE))
      nxt_st.enable = st_ff.enable | field_bits(wdata_i);
    if (wr_i && hit(addr_i, `REG_IRQ_DISABLE))
      nxt_st.enable = st_ff.enable & ~field_bits(wdata_i);

    // Read clears; an event in the same cycle survives the clear
    nxt_st.status = (st_ff.status & ~status_clear) | events;

    nxt_st.rdata = `WORD_ZERO;
    if (rd_i)
    begin
      unique case (addr_i)
        `REG_STATUS: nxt_st.rdata = to_word(st_ff.status);
        `REG_IRQ_MASK: nxt_st.rdata = to_word(st_ff.enable);
        `REG_RX_HOLD: nxt_st.rdata = byte_word(hif.rx_byte);
        `REG_TX_HOLD: nxt_st.rdata = byte_word(hif.tx_byte);
        // Enable and disable are write-only and read as zero, as does any unmapped word
        default: nxt_st.rdata = `WORD_ZERO;
      endcase
    end

    // Built from the next values so the line follows status and mask with no extra lag
    nxt_st.irq = |(nxt_st.status & nxt_st.enable);
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      st_ff <= '{rdata: `WORD_ZERO, enable: `IRQ_ENABLE_RST, status: `STATUS_RST, irq: 1'b0};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign rdata_o = st_ff.rdata;
  assign irq_o = st_ff.irq;
  assign tx_byte_o = hif.tx_byte;
  assign tx_valid_o = hif.tx_full;

endmodule // serial_irq_regs

// [engine_model.sv]
// Stand-in for the bus protocol engine beyond the holding registers
`timescale 1ns/10ps
module engine_model (
  input wire logic clk_i,
  output logic done_o,
  output logic nack_o,
  output logic rxv_o,
  output hold_pkg::byte_t rxb_o,
  output logic take_o
);
  import hold_pkg::*;
  initial
  begin
    {done_o, nack_o, rxv_o, take_o} = 4'h0;
    rxb_o = 8'h5a;
  end
  // Byte lines flip when idle so a stale byte never passes for a fresh one
  task pulse(input logic [3:0] m, input byte_t b);
    {done_o, nack_o, rxv_o, take_o} <= m;
    rxb_o <= b;
    @(posedge clk_i);
    {done_o, nack_o, rxv_o, take_o} <= 4'h0;
    rxb_o <= ~b;
  endtask
endmodule // engine_model

// [serial_irq_regs_monitor.sv]
// Port checks for the interrupt and holding register block
`timescale 1ns/10ps
module serial_irq_regs_monitor (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire hold_pkg::addr_t addr_i,
  input wire hold_pkg::word_t wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire hold_pkg::word_t rdata_o,
  input wire logic irq_o,
  input wire logic transfer_done_i,
  input wire logic nack_i,
  input wire logic rx_valid_i,
  input wire hold_pkg::byte_t rx_byte_i,
  input wire logic tx_take_i,
  input wire hold_pkg::byte_t tx_byte_o,
  input wire logic tx_valid_o
);
  import hold_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  en_mask_a:
  assert property (wr_i && addr_i == 8'h24 ##1 rd_i && addr_i == 8'h2c |=>
    (rdata_o[8:0] & $past(wdata_i[8:0], 2)) == ($past(wdata_i[8:0], 2) & 9'h1c7))
    else $error("enable lost");
  dis_mask_a:
  assert property (wr_i && addr_i == 8'h28 ##1 rd_i && addr_i == 8'h2c |=>
    (rdata_o[8:0] & $past(wdata_i[8:0], 2)) == 9'h0) else $error("disable lost");
  mask_rsvd_a:
  assert property (rd_i && addr_i == 8'h2c |=> rdata_o[31:9] == 0 && rdata_o[5:3] == 0)
    else $error("reserved bit");
  rx_read_a:
  assert property (rx_valid_i ##1 rd_i && addr_i == 8'h30 |=>
    rdata_o == {24'h0, $past(rx_byte_i, 2)}) else $error("rx byte");
  tx_load_a:
  assert property (wr_i && addr_i == 8'h34 |=> tx_valid_o && tx_byte_o == $past(wdata_i[7:0]))
    else $error("tx load");
  tx_take_a:
  assert property (tx_take_i && tx_valid_o && !wr_i |=> !tx_valid_o) else $error("tx take");
  irq_rise_a:
  assert property ($rose(irq_o) |-> $past(nack_i || transfer_done_i || wr_i)
    || $past(rx_valid_i || tx_take_i, 2)) else $error("irq rise");
  irq_fall_a:
  assert property ($fell(irq_o) |-> $past(rd_i || wr_i)) else $error("irq fall");
  cover property (nack_i ##1 irq_o);
  cover property (rx_valid_i ##1 rd_i && addr_i == 8'h30);
  cover property ($fell(irq_o));
endmodule // serial_irq_regs_monitor

bind serial_irq_regs serial_irq_regs_monitor mon_u (.clk_i, .rst_n_i, .addr_i, .wdata_i,
  .wr_i, .rd_i, .rdata_o, .irq_o, .transfer_done_i, .nack_i, .rx_valid_i, .rx_byte_i,
  .tx_take_i, .tx_byte_o, .tx_valid_o);

// [serial_irq_regs_tb.sv]
// Self-checking bench for the interrupt and holding register block
`timescale 1ns/10ps
module serial_irq_regs_tb;
  import hold_pkg::*;
  logic clk_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0, rd_d = 0;
  logic irq_o, transfer_done_i, nack_i, rx_valid_i, tx_take_i, tx_valid_o;
  addr_t addr_i = 0;
  word_t wdata_i = 0, rdata_o, r, expq[$];
  byte_t rx_byte_i, tx_byte_o, b;
  int error_cnt = 0, cmp_count = 0, cyc = 0, en = 0;
  always #12.5 clk_i = ~clk_i;
  serial_irq_regs dut_u (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .irq_o,
    .transfer_done_i, .nack_i, .rx_valid_i, .rx_byte_i, .tx_take_i, .tx_byte_o, .tx_valid_o);
  engine_model eng_u (.clk_i, .done_o(transfer_done_i), .nack_o(nack_i), .rxv_o(rx_valid_i),
    .rxb_o(rx_byte_i), .take_o(tx_take_i));
  task chk(input word_t seen, input word_t exp);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task summarize;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Strobes are left up; the next call or an idle cycle lowers them
  task bus(input logic w, input logic s, input addr_t a, input word_t d);
    wr_i <= w;
    rd_i <= s;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
  endtask
  task rd(input addr_t a, input word_t e);
    expq.push_back(e);
    bus(0, 1, a, 0);
  endtask
  task lvl(input bit s, input word_t e);
    @(negedge clk_i);
    chk(s ? {tx_valid_o, 23'h0, tx_byte_o} : 32'(irq_o), e);
    @(posedge clk_i);
  endtask
  // Read data is looked at on the edge after the read, before it is replaced
  always @(posedge clk_i)
  begin
    if (rd_d)
      chk(rdata_o, expq.pop_front());
    rd_d <= rd_i;
    cyc++;
    if (cyc == 2000)
    begin
      error_cnt++;
      summarize;
    end
  end
  initial
  begin
    void'($urandom(61768));
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1;
    @(posedge clk_i);
    rd(8'h2c, 0);
    rd(8'h20, 32'h4);
    bus(1, 0, 8'h2c, '1);
    rd(8'h3c, 0);
    rd(8'h28, 0);
    repeat (6)
    begin
      r = $urandom;
      bus(1, 0, 8'h24, r);
      en |= r & 32'h1c7;
      rd(8'h2c, en);
      r = $urandom;
      bus(1, 0, 8'h28, r);
      en &= ~r;
      rd(8'h2c, en);
    end
    bus(1, 0, 8'h24, 32'h1c7);
    bus(0, 0, 0, 0);
    lvl(0, 0);
    for (int k = 0; k < 2; k++)
    begin
      eng_u.pulse(k ? 4'h4 : 4'h8, 0);
      lvl(0, 1);
      rd(8'h20, k ? 32'h100 : 32'h1);
      bus(0, 0, 0, 0);
      lvl(0, 0);
    end
    bus(1, 0, 8'h28, 32'h100);
    bus(0, 0, 0, 0);
    eng_u.pulse(4, 0);
    bus(0, 0, 0, 0);
    lvl(0, 0);
    rd(8'h20, 32'h100);
    bus(0, 0, 0, 0);
    b = $urandom;
    eng_u.pulse(2, b);
    rd(8'h30, {24'h0, b});
    bus(0, 0, 0, 0);
    eng_u.pulse(2, ~b);
    bus(0, 0, 0, 0);
    eng_u.pulse(2, b + 8'h01);
    bus(0, 0, 0, 0);
    rd(8'h30, {24'h0, b + 8'h01});
    rd(8'h20, 32'h42);
    r = $urandom;
    bus(1, 0, 8'h34, r);
    rd(8'h34, {24'h0, r[7:0]});
    bus(0, 0, 0, 0);
    lvl(1, {1'b1, 23'h0, r[7:0]});
    eng_u.pulse(1, 0);
    bus(0, 0, 0, 0);
    rd(8'h20, 32'h4);
    bus(0, 0, 0, 0);
    eng_u.pulse(1, 0);
    bus(0, 0, 0, 0);
    rd(8'h20, 32'h80);
    bus(0, 0, 0, 0);
    repeat (2) @(posedge clk_i);
    summarize;
  end
endmodule // serial_irq_regs_tb
